// ===== verilog/aod_decoder.sv
// accumulator opcode decoder with avalon-mm control and status registers
`timescale 1ns/1ps
`default_nettype none
module aod_decoder
  import aod_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // program memory side
  input wire logic [15:0] prog_word,
  input wire logic prog_valid,
  // machine state used by the decode
  input wire aod_cond_type status_cond_group,
  input wire logic test_flag,
  input wire logic branch_input_pin,
  input wire logic [15:0] temp_register_one,
  input wire logic [8:0] data_page,
  input wire logic [15:0] aux_reg_value,
  // to the accumulator datapath
  output aod_dec_type dec_out,
  output logic dec_valid
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // peripheral registers live behind the slower internal bus
  // window bounds are inclusive at both ends
  function automatic logic is_periph(input logic [15:0] a);
    is_periph = (a >= AOD_PERIPH_LO) && (a <= AOD_PERIPH_HI);
  endfunction

  // forms that carry a data-memory operand address
  function automatic logic is_mem_op(input aod_op_type op);
    is_mem_op = (op == AOD_OP_ADD_SHIFT) || (op == AOD_OP_ADD_HIGH) ||
                (op == AOD_OP_ADD_VAR) || (op == AOD_OP_AND_DATA);
  endfunction

  function automatic logic [15:0] eff_addr(input logic [15:0] w,
                                           input logic [8:0] dp,
                                           input logic [15:0] ar);
    // clear bit 7 means page plus seven-bit offset
    if (w[7]) begin
      eff_addr = ar;
    end else begin
      eff_addr = {dp, w[6:0]};
    end
  endfunction

  // ****************************************************************
  // state and signals
  // ****************************************************************
  typedef enum logic [0:0] {AOD_ST_FIRST, AOD_ST_IMM} aod_state_type;

  // decode path
  aod_state_type state;
  aod_dec_type next_dec;
  aod_dec_type held;
  logic next_valid;
  logic next_wait_imm;

  // software-visible registers
  logic [31:0] ctrl;
  logic [31:0] decode_count;
  logic [15:0] last_word;
  logic enable;

  // condition and operand address path
  logic [3:0] mask;
  logic [3:0] want;
  logic [3:0] hit;
  logic sel_ok;
  logic periph;
  logic [15:0] ea;

  // a cleared enable bit refuses every offered word
  assign enable = ctrl[AOD_CTRL_EN_BIT];

  // ****************************************************************
  // condition evaluation
  // ****************************************************************

  // a mask of zero leaves only the select bits to decide
  always_comb begin
    mask = prog_word[AOD_MASK_LSB +: 4];
    want = prog_word[AOD_STATE_LSB +: 4];
    hit = mask & ~(status_cond_group ^ want);
    case (prog_word[AOD_SEL_LSB +: 2])
      AOD_SEL_PIN_LOW: sel_ok = ~branch_input_pin;
      AOD_SEL_FLAG_SET: sel_ok = test_flag;
      AOD_SEL_FLAG_CLR: sel_ok = ~test_flag;
      default: sel_ok = 1'b1;
    endcase
  end

  // operand address and its peripheral window test
  assign ea = eff_addr(prog_word, data_page, aux_reg_value);
  assign periph = is_periph(ea);

  // ****************************************************************
  // opcode decode
  // ****************************************************************

  // the long immediate form parks its first word and waits for the next
  always_comb begin
    next_dec = '0;
    next_valid = 1'b0;
    next_wait_imm = 1'b0;
    next_dec.words = AOD_WORDS_ONE;
    next_dec.cycles = AOD_CYC_ONE;
    next_dec.indirect = prog_word[7];
    next_dec.mem_addr = ea;
    // second word of a pair supplies only the immediate
    if (prog_valid && enable && state == AOD_ST_IMM) begin
      next_dec = held;
      next_dec.imm = prog_word;
      next_valid = 1'b1;
    end else if (prog_valid && enable) begin
      next_valid = 1'b1;
      if (prog_word == AOD_PAT_ABS) begin
        next_dec.op = AOD_OP_ABS;
      end else if (prog_word == AOD_PAT_ADD_BACKUP_WITH_CARRY_OP) begin
        next_dec.op = AOD_OP_ADD_BACKUP_WITH_CARRY_OP;
      end else if (prog_word[15:4] == AOD_TOP_ADD_LONG) begin
        next_dec.op = AOD_OP_ADD_LONG;
        next_dec.shift = prog_word[3:0];
        next_dec.words = AOD_WORDS_TWO;
        next_dec.cycles = AOD_CYC_TWO;
        next_valid = 1'b0;
        next_wait_imm = 1'b1;
      end else if (prog_word[15:8] == AOD_TOP_ADD_SHORT) begin
        next_dec.op = AOD_OP_ADD_SHORT;
        next_dec.imm = {8'h00, prog_word[7:0]};
      end else if (prog_word[15:12] == AOD_TOP_ADD_SHIFT) begin
        next_dec.op = AOD_OP_ADD_SHIFT;
        next_dec.shift = prog_word[11:8];
      end else if (prog_word[15:8] == AOD_TOP_ADD_HIGH) begin
        next_dec.op = AOD_OP_ADD_HIGH;
        next_dec.shift = 4'h0;
      end else if (prog_word[15:8] == AOD_TOP_ADD_VAR) begin
        next_dec.op = AOD_OP_ADD_VAR;
        next_dec.shift = temp_register_one[3:0];
      end else if (prog_word[15:8] == AOD_TOP_AND_DATA) begin
        next_dec.op = AOD_OP_AND_DATA;
      end else if (prog_word[15:13] == AOD_TOP_COND) begin
        // any selected condition in its wanted state satisfies
        next_dec.cond_met = sel_ok & ((mask == 4'h0) | (|hit));
        case (prog_word[11:10])
          AOD_SUB_BRANCH: next_dec.op = AOD_OP_BRANCH;
          AOD_SUB_EXEC: begin
            next_dec.op = AOD_OP_EXEC;
            // count bit clear runs one instruction, set runs two
            next_dec.exec_count = prog_word[AOD_COUNT_BIT] ?
                                  2'h2 : 2'h1;
          end
          AOD_SUB_CALL: next_dec.op = AOD_OP_CALL;
          default: next_dec.op = AOD_OP_NONE;
        endcase
      end else begin
        next_dec.op = AOD_OP_NONE;
      end
      // only memory-reference forms carry an operand address
      if (is_mem_op(next_dec.op)) begin
        next_dec.cycles = periph ? AOD_CYC_TWO : AOD_CYC_ONE;
      end else begin
        next_dec.indirect = 1'b0;
        next_dec.mem_addr = 16'h0000;
      end
    end
  end

  // ****************************************************************
  // two-word sequencer
  // ****************************************************************

  // tracks whether the next offered word is a long-add immediate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= AOD_ST_FIRST;
    end else if (!enable) begin
      state <= AOD_ST_FIRST; // disabling drops a half-taken long add
    end else if (prog_valid) begin
      case (state)
        AOD_ST_FIRST: begin
          if (next_wait_imm) begin
            state <= AOD_ST_IMM;
          end
        end
        AOD_ST_IMM: begin
          state <= AOD_ST_FIRST; // the immediate completes the pair
        end
        default: begin
          state <= AOD_ST_FIRST;
        end
      endcase
    end
  end

  // first word of a long add, parked until its immediate arrives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      held <= '0;
    end else if (prog_valid && next_wait_imm) begin
      held <= next_dec;
    end
  end

  // ****************************************************************
  // decode pipeline registers
  // ****************************************************************

  // decoded controls, held until the next decode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_out <= '0;
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= next_valid;
      if (next_valid) begin
        dec_out <= next_dec;
      end
    end
  end

  // statistics for software
  // the tally wraps silently at its full width
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      decode_count <= 32'h0000_0000;
      last_word <= 16'h0000;
    end else if (next_valid) begin
      decode_count <= decode_count + 32'h0000_0001;
      last_word <= prog_word;
    end
  end

  // ****************************************************************
  // avalon-mm slave
  // ****************************************************************

  // one wait cycle per access keeps the read path registered
  // a request is answered on its second edge, never sooner
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // control register, byte lane 0 only holds live bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= AOD_CTRL_RESET;
    end else if (write && !waitrequest && address == AOD_ADDR_CTRL &&
                 byteenable[0]) begin
      ctrl <= {31'h0000_0000, writedata[AOD_CTRL_EN_BIT]};
    end
  end

  // read data loaded in the wait cycle; unmapped reads give zero
  // status packs last word, cond, cycles, pair wait and op
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      case (address)
        AOD_ADDR_CTRL: readdata <= ctrl;
        AOD_ADDR_STATUS: readdata <= {last_word, 3'h0, dec_out.cond_met,
                                      dec_out.cycles, state == AOD_ST_IMM,
                                      4'h0, dec_out.op};
        AOD_ADDR_COUNT: readdata <= decode_count;
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== verilog/aod_pkg.sv
// constants, types and layouts for the accumulator opcode decoder
package aod_pkg;

  // ****************************************************************
  // register map (word aligned byte addresses)
  // ****************************************************************
  localparam logic [3:0] AOD_ADDR_CTRL = 4'h0;
  localparam logic [3:0] AOD_ADDR_STATUS = 4'h4;
  localparam logic [3:0] AOD_ADDR_COUNT = 4'h8;
  localparam logic [31:0] AOD_CTRL_RESET = 32'h0000_0001;
  localparam int AOD_CTRL_EN_BIT = 0;

  // ****************************************************************
  // opcode patterns
  // ****************************************************************
  localparam logic [15:0] AOD_PAT_ABS = 16'hbe00;
  localparam logic [15:0] AOD_PAT_ADD_BACKUP_WITH_CARRY_OP = 16'hbe11;
  localparam logic [3:0] AOD_TOP_ADD_SHIFT = 4'h2;
  localparam logic [7:0] AOD_TOP_ADD_SHORT = 8'hb8;
  localparam logic [11:0] AOD_TOP_ADD_LONG = 12'hbf9;
  localparam logic [7:0] AOD_TOP_ADD_HIGH = 8'h61;
  localparam logic [7:0] AOD_TOP_ADD_VAR = 8'h67;
  localparam logic [7:0] AOD_TOP_AND_DATA = 8'h6e;
  // conditional group: bits 15:13 and 11:10 select the kind
  localparam logic [2:0] AOD_TOP_COND = 3'h7;
  localparam logic [1:0] AOD_SUB_BRANCH = 2'h0;
  localparam logic [1:0] AOD_SUB_EXEC = 2'h1;
  localparam logic [1:0] AOD_SUB_CALL = 2'h2;

  // ****************************************************************
  // condition field layout
  // ****************************************************************
  localparam int AOD_MASK_LSB = 0;
  localparam int AOD_STATE_LSB = 4;
  localparam int AOD_SEL_LSB = 8;
  localparam int AOD_COUNT_BIT = 12;
  localparam logic [1:0] AOD_SEL_PIN_LOW = 2'h0;
  localparam logic [1:0] AOD_SEL_FLAG_SET = 2'h1;
  localparam logic [1:0] AOD_SEL_FLAG_CLR = 2'h2;

  // ****************************************************************
  // peripheral window and cycle counts
  // ****************************************************************
  localparam logic [15:0] AOD_PERIPH_LO = 16'h0020;
  localparam logic [15:0] AOD_PERIPH_HI = 16'h004f;
  localparam logic [2:0] AOD_CYC_ONE = 3'h1;
  localparam logic [2:0] AOD_CYC_TWO = 3'h2;
  localparam logic [1:0] AOD_WORDS_ONE = 2'h1;
  localparam logic [1:0] AOD_WORDS_TWO = 2'h2;

  typedef enum logic [3:0] {
    AOD_OP_NONE, AOD_OP_ABS, AOD_OP_ADD_BACKUP_WITH_CARRY_OP, AOD_OP_ADD_SHIFT, AOD_OP_ADD_SHORT,
    AOD_OP_ADD_LONG, AOD_OP_ADD_HIGH, AOD_OP_ADD_VAR, AOD_OP_AND_DATA,
    AOD_OP_BRANCH, AOD_OP_EXEC, AOD_OP_CALL
  } aod_op_type;

  // status_cond_group order: zero, negative, overflow, carry
  typedef struct packed {
    logic zero;
    logic negative;
    logic overflow;
    logic carry;
  } aod_cond_type;

  typedef struct packed {
    aod_op_type op;
    logic [3:0] shift;
    logic indirect;
    logic [15:0] mem_addr;
    logic [15:0] imm;
    logic [1:0] words;
    logic [2:0] cycles;
    logic cond_met;
    logic [1:0] exec_count;
  } aod_dec_type;

endpackage

// ===== tb/aod_decoder_asserts.sv
// checker for the opcode decoder, watching only its ports
`timescale 1ns/1ps
`default_nettype none
module aod_chk
  import aod_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic [15:0] prog_word,
  input wire logic prog_valid,
  input wire logic [15:0] temp_register_one,
  input wire logic [8:0] data_page,
  input wire logic [15:0] aux_reg_value,
  input wire aod_dec_type dec_out,
  input wire logic dec_valid
);
  // ****************************************************************
  // shadow state
  // ****************************************************************
  logic en, pend, one, tail, mem;
  logic [15:0] lw, ea;
  logic [3:0] lt;
  // enable copy, so refused words are not expected to decode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en <= 1'b1;
    end else if (write && !waitrequest && address == AOD_ADDR_CTRL
                 && byteenable[0]) begin
      en <= writedata[0];
    end
  end
  // kind of the word taken last; a disable drops a pending long form
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
      one <= 1'b0;
      tail <= 1'b0;
    end else begin
      pend <= en && (prog_valid ? !pend
        && prog_word[15:4] == AOD_TOP_ADD_LONG : pend);
      one <= prog_valid && en && !pend
        && prog_word[15:4] != AOD_TOP_ADD_LONG;
      tail <= prog_valid && en && pend;
    end
  end
  // operands as they stood when the word was taken
  always_ff @(posedge clk) begin
    lw <= prog_word;
    lt <= temp_register_one[3:0];
    ea <= prog_word[7] ? aux_reg_value : {data_page, prog_word[6:0]};
  end
  assign mem = one && (lw[15:12] == AOD_TOP_ADD_SHIFT
    || lw[15:8] inside {AOD_TOP_ADD_HIGH, AOD_TOP_ADD_VAR, AOD_TOP_AND_DATA});
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_abs_form: assert property (
    one && lw == AOD_PAT_ABS |-> dec_valid && dec_out.op == AOD_OP_ABS
      && dec_out.cycles == AOD_CYC_ONE && dec_out.words == AOD_WORDS_ONE)
    else $error("absolute value word misdecoded");
  chk_shift_form: assert property (
    one && lw[15:12] == AOD_TOP_ADD_SHIFT |-> dec_valid
      && dec_out.op == AOD_OP_ADD_SHIFT && dec_out.shift == lw[11:8])
    else $error("shifted add misdecoded");
  chk_short_form: assert property (
    one && lw[15:8] == AOD_TOP_ADD_SHORT |-> dec_out.op == AOD_OP_ADD_SHORT
      && dec_out.imm[7:0] == lw[7:0] && dec_out.cycles == AOD_CYC_ONE)
    else $error("short immediate add misdecoded");
  chk_long_form: assert property (
    tail |-> dec_valid && dec_out.op == AOD_OP_ADD_LONG && dec_out.imm == lw
      && dec_out.words == AOD_WORDS_TWO && dec_out.cycles == AOD_CYC_TWO)
    else $error("long immediate add misdecoded");
  chk_var_shift: assert property (
    one && lw[15:8] == AOD_TOP_ADD_VAR |-> dec_out.op == AOD_OP_ADD_VAR
      && dec_out.shift == lt)
    else $error("variable shift not taken from temp register");
  chk_and_form: assert property (
    one && lw[15:8] == AOD_TOP_AND_DATA |-> dec_valid
      && dec_out.op == AOD_OP_AND_DATA && dec_out.words == AOD_WORDS_ONE)
    else $error("and with data value misdecoded");
  chk_mem_cycles: assert property (
    mem |-> dec_out.indirect == lw[7] && dec_out.mem_addr == ea
      && dec_out.cycles == ((ea >= AOD_PERIPH_LO && ea <= AOD_PERIPH_HI)
      ? AOD_CYC_TWO : AOD_CYC_ONE))
    else $error("operand address or peripheral cycle wrong");
  chk_no_stray: assert property (
    dec_valid |-> one || tail)
    else $error("decode pulse without a complete instruction");
endmodule
bind aod_decoder aod_chk u_chk (.clk(clk), .nrst(nrst), .address(address),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .waitrequest(waitrequest), .prog_word(prog_word),
  .prog_valid(prog_valid), .temp_register_one(temp_register_one),
  .data_page(data_page), .aux_reg_value(aux_reg_value),
  .dec_out(dec_out), .dec_valid(dec_valid));
`default_nettype wire

// ===== tb/aod_prog_mem.sv
// program memory model offering queued words to the decoder
`timescale 1ns/1ps
`default_nettype none
module aod_prog_mem
  import aod_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  output logic [15:0] prog_word,
  output logic prog_valid
);
  logic [15:0] q[$];
  logic gap;
  // slow mode idles one cycle between words; each idle cycle inverts the word shown
  // so a single idle cycle never shows the stale value again
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_valid <= 1'b0;
      prog_word <= 16'h0000;
      gap <= 1'b0;
    end else if (q.size() != 0 && !(slow && gap)) begin
      prog_word <= q.pop_front();
      prog_valid <= 1'b1;
      gap <= 1'b1;
    end else begin
      prog_word <= ~prog_word;
      prog_valid <= 1'b0;
      gap <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the accumulator opcode decoder
`timescale 1ns/1ps
`default_nettype none
module testbench
  import aod_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, slow = 1'b0;
  logic test_flag = 1'b0, branch_input_pin = 1'b1, waitrequest, dec_valid;
  logic prog_valid;
  logic [3:0] address = 4'h0, byteenable = 4'hf;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [15:0] prog_word, temp_register_one = 16'h0, aux_reg_value = 16'h0;
  logic [15:0] lf = 16'h000e;
  logic [8:0] data_page = 9'h000;
  aod_cond_type status_cond_group = '0;
  aod_dec_type dec_out;
  aod_dec_type eq[$];
  int error_cnt = 0, n_checks = 0, ndec = 0;
  logic [15:0] corner [8] = '{16'hbe00, 16'hbe11, 16'h2f20, 16'hb8ff,
    16'hbf9f, 16'h614f, 16'h6e50, 16'h671f};
  aod_decoder DUT (.clk(clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .prog_word(prog_word),
    .prog_valid(prog_valid), .status_cond_group(status_cond_group),
    .test_flag(test_flag), .branch_input_pin(branch_input_pin),
    .temp_register_one(temp_register_one), .data_page(data_page),
    .aux_reg_value(aux_reg_value), .dec_out(dec_out), .dec_valid(dec_valid));
  aod_prog_mem PM (.clk(clk), .nrst(nrst), .slow(slow),
    .prog_word(prog_word), .prog_valid(prog_valid));
  initial forever #5 clk = ~clk;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected decode of one word under the present machine inputs
  function automatic aod_dec_type exp_dec(input logic [15:0] w);
    aod_dec_type r;
    logic [15:0] ea;
    logic ok;
    r = '0;
    r.words = AOD_WORDS_ONE;
    r.cycles = AOD_CYC_ONE;
    r.imm = {8'h00, w[7:0]};
    r.shift = w[11:8];
    r.exec_count = w[12] ? 2'h2 : 2'h1;
    ok = w[9:8] == AOD_SEL_PIN_LOW ? !branch_input_pin :
      w[9:8] == AOD_SEL_FLAG_SET ? test_flag :
      w[9:8] == AOD_SEL_FLAG_CLR ? !test_flag : 1'b1;
    r.cond_met = ok && (w[3:0] == 4'h0
      || |(w[3:0] & ~(w[7:4] ^ status_cond_group)));
    ea = w[7] ? aux_reg_value : {data_page, w[6:0]};
    if (w == AOD_PAT_ABS) r.op = AOD_OP_ABS;
    else if (w == AOD_PAT_ADD_BACKUP_WITH_CARRY_OP) r.op = AOD_OP_ADD_BACKUP_WITH_CARRY_OP;
    else if (w[15:12] == AOD_TOP_ADD_SHIFT) r.op = AOD_OP_ADD_SHIFT;
    else if (w[15:8] == AOD_TOP_ADD_SHORT) r.op = AOD_OP_ADD_SHORT;
    else if (w[15:4] == AOD_TOP_ADD_LONG) begin
      r.op = AOD_OP_ADD_LONG;
      r.shift = w[3:0];
      r.words = AOD_WORDS_TWO;
      r.cycles = AOD_CYC_TWO;
    end else if (w[15:8] == AOD_TOP_ADD_HIGH) r.op = AOD_OP_ADD_HIGH;
    else if (w[15:8] == AOD_TOP_ADD_VAR) begin
      r.op = AOD_OP_ADD_VAR;
      r.shift = temp_register_one[3:0];
    end else if (w[15:8] == AOD_TOP_AND_DATA) r.op = AOD_OP_AND_DATA;
    else if (w[15:13] == AOD_TOP_COND && w[11:10] != 2'h3)
      r.op = aod_op_type'(AOD_OP_BRANCH + w[11:10]);
    if (r.op inside {AOD_OP_ADD_SHIFT, AOD_OP_ADD_HIGH, AOD_OP_ADD_VAR,
        AOD_OP_AND_DATA} && ea >= AOD_PERIPH_LO && ea <= AOD_PERIPH_HI)
      r.cycles = AOD_CYC_TWO;
    return r;
  endfunction
  task automatic fail(input string m);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] x);
    n_checks++;
    if (got !== x) fail("register value");
  endtask
  // fields that the chosen op defines are compared, the rest left open
  task automatic chk_dec(input aod_dec_type x);
    n_checks++;
    if (dec_out.op !== x.op) fail("operation");
    else if (x.op inside {AOD_OP_BRANCH, AOD_OP_EXEC, AOD_OP_CALL}) begin
      if (dec_out.cond_met !== x.cond_met || (x.op == AOD_OP_EXEC
          && dec_out.exec_count !== x.exec_count)) fail("condition");
    end else if (x.op != AOD_OP_NONE) begin
      if ({dec_out.words, dec_out.cycles} !== {x.words, x.cycles})
        fail("size or cycles");
      if (x.op inside {AOD_OP_ADD_SHIFT, AOD_OP_ADD_VAR, AOD_OP_ADD_LONG}
          && dec_out.shift !== x.shift) fail("shift");
      if (x.op inside {AOD_OP_ADD_SHORT, AOD_OP_ADD_LONG}
          && dec_out.imm !== x.imm) fail("immediate");
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic put(input logic [15:0] w);
    aod_dec_type x;
    x = exp_dec(w);
    PM.q.push_back(w);
    ndec++;
    if (x.op == AOD_OP_ADD_LONG) begin
      lf = nx(lf);
      x.imm = lf;
      PM.q.push_back(lf);
    end
    eq.push_back(x);
  endtask
  task automatic drain;
    while (PM.q.size() != 0) @(posedge clk);
    repeat (4) @(posedge clk);
    n_checks++;
    if (eq.size() != 0) fail("decode missing");
    eq.delete();
  endtask
  // fresh machine inputs; held until the queued words have drained
  task automatic mix;
    @(posedge clk);
    lf = nx(lf);
    status_cond_group <= aod_cond_type'(lf[3:0]);
    test_flag <= lf[4];
    branch_input_pin <= lf[5];
    slow <= lf[6];
    temp_register_one <= lf;
    data_page <= {8'h00, lf[7]};
    aux_reg_value <= {9'h000, lf[15:9]};
    @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // every decode pulse is matched against the oldest expectation
  always @(posedge clk) begin
    if (nrst && dec_valid === 1'b1) begin
      if (eq.size() == 0) fail("stray decode");
      else chk_dec(eq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail("timeout");
    complete_run;
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, AOD_ADDR_CTRL, 32'h0, 4'hf);
    chk_reg(q, AOD_CTRL_RESET);
    bus(1'b1, AOD_ADDR_CTRL, 32'h0, 4'he);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    chk_reg(q, 32'h0);
    bus(1'b0, AOD_ADDR_CTRL, 32'h0, 4'hf);
    chk_reg(q, AOD_CTRL_RESET);
    $display("test registers done");
    mix;
    data_page <= 9'h000;
    @(posedge clk);
    foreach (corner[i]) put(corner[i]);
    put(16'h6e20);
    drain;
    $display("test corner words done");
    for (int k = 0; k < 24; k++) begin
      mix;
      for (int s = 0; s < 4; s++) begin
        lf = nx(lf);
        put({3'h7, lf[12], 2'(k % 3), 2'(s), lf[7:0]});
      end
      drain;
    end
    $display("test conditions done");
    for (int k = 0; k < 240; k++) begin
      if (k % 16 == 0) begin
        drain;
        mix;
      end
      lf = nx(lf);
      put(lf);
    end
    drain;
    $display("test random words done");
    PM.q.push_back({AOD_TOP_ADD_LONG, 4'h3});
    drain;
    bus(1'b1, AOD_ADDR_CTRL, 32'h0, 4'hf);
    PM.q.push_back(AOD_PAT_ABS);
    drain;
    bus(1'b1, AOD_ADDR_CTRL, 32'h1, 4'hf);
    put(AOD_PAT_ABS);
    drain;
    bus(1'b0, AOD_ADDR_COUNT, 32'h0, 4'hf);
    chk_reg(q, ndec);
    bus(1'b0, AOD_ADDR_STATUS, 32'h0, 4'hf);
    chk_reg(q, {AOD_PAT_ABS, 3'h0, 1'b0, AOD_CYC_ONE, 1'b0, 4'h0,
      4'(AOD_OP_ABS)});
    $display("test refusal done");
    complete_run;
  end
endmodule
`default_nettype wire
